// ---- src/via_pkg.sv ----
package via_pkg;
   // Sizes
   localparam int NUM_PINS = 8;
   localparam int NUM_SRC = 16;
   localparam int SRC_W = 4;
   localparam int CNT_W = 3;
   // Register addresses
   localparam logic [15:0] ADDR_RISE_SEL = 16'hFF48;
   localparam logic [15:0] ADDR_FALL_SEL = 16'hFF49;
   localparam logic [15:0] ADDR_PSW = 16'hFF1E;
   // Reset values
   localparam logic [7:0] EDGE_SEL_RESET = 8'h00;
   localparam logic [7:0] PSW_RESET = 8'h02;
   localparam logic [7:0] RD_UNMAPPED = 8'h00;
   // Status word fields
   localparam int ACC_EN_BIT = 7;
   localparam int SVC_LVL_BIT = 1;
   // Acceptance latency in CPU clocks
   localparam int LAT_MIN_HI_CLK = 7;
   localparam int LAT_MIN_LO_CLK = 8;
   localparam int LAT_MAX_HI_CLK = 32;
   localparam int LAT_MAX_LO_CLK = 33;
   localparam int SEQ_OVERHEAD_CLK = 5;
   localparam logic [CNT_W-1:0] WAIT_HI_CNT =
      CNT_W'(LAT_MIN_HI_CLK - SEQ_OVERHEAD_CLK - 1);
   localparam logic [CNT_W-1:0] WAIT_LO_CNT =
      CNT_W'(LAT_MIN_LO_CLK - SEQ_OVERHEAD_CLK - 1);
   // Vector table
   localparam logic [15:0] VEC_BASE = 16'h0004;
   localparam logic [15:0] VEC_TRAP = 16'h003E;
   // Stacking and vector sequence
   typedef enum logic [2:0] {
      VIA_IDLE,
      VIA_WAIT,
      VIA_PUSH_PSW,
      VIA_PUSH_PC,
      VIA_LOAD_VEC
   } via_seq_type;
endpackage

// ---- src/via_arb_if.sv ----
`timescale 1ns/1ps
interface via_arb_if;
   import via_pkg::*;
   logic [NUM_SRC-1:0] ready;
   logic [NUM_SRC-1:0] urgency;
   logic accEn;
   logic svcLvl;
   logic grant;
   logic [SRC_W-1:0] grantIdx;
   logic grantUrg;
   modport ctrl (output ready, urgency, accEn, svcLvl,
      input grant, grantIdx, grantUrg);
   modport arb (input ready, urgency, accEn, svcLvl,
      output grant, grantIdx, grantUrg);
endinterface

// ---- src/via_edge_detect.sv ----
`timescale 1ns/1ps
module via_edge_detect import via_pkg::*; (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [NUM_PINS-1:0] pin,
   input wire logic [NUM_PINS-1:0] riseSel,
   input wire logic [NUM_PINS-1:0] fallSel,
   output logic [NUM_PINS-1:0] edgeHit
);
   logic [NUM_PINS-1:0] pinPrev_q;

   // Previous pin level
   always_ff @(posedge mclk) begin
      if (rst) begin
         pinPrev_q <= '0;
      end else begin
         pinPrev_q <= pin;
      end
   end

   // Per-pin edge selection
   genvar g;
   generate
      for (g = 0; g < NUM_PINS; g++) begin : gPin
         assign edgeHit[g] = (riseSel[g] & pin[g] & ~pinPrev_q[g]) |
            (fallSel[g] & ~pin[g] & pinPrev_q[g]);
      end
   endgenerate
endmodule // via_edge_detect

// ---- src/via_arbiter.sv ----
`timescale 1ns/1ps
module via_arbiter import via_pkg::*; (
   via_arb_if.arb bus
);
   logic [NUM_SRC-1:0] eligible;
   logic [NUM_SRC-1:0] hiSet;
   logic [NUM_SRC-1:0] pickSet;

   // Eligibility by enable and level in service
   always_comb begin
      if (!bus.accEn) begin
         eligible = '0;
      end else if (!bus.svcLvl) begin
         eligible = bus.ready & ~bus.urgency;
      end else begin
         eligible = bus.ready;
      end
      hiSet = eligible & ~bus.urgency;
      pickSet = (|hiSet) ? hiSet : eligible;
   end

   // Lowest index wins among equal level
   always_comb begin
      bus.grantIdx = '0;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (pickSet[i]) begin
            bus.grantIdx = SRC_W'(i);
         end
      end
      bus.grant = |pickSet;
      bus.grantUrg = bus.urgency[bus.grantIdx];
   end
endmodule // via_arbiter

// ---- src/via_irq_ctrl.sv ----
`timescale 1ns/1ps
module via_irq_ctrl import via_pkg::*; (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [NUM_PINS-1:0] extIrqPin,
   input wire logic [NUM_PINS-1:0] periphReq,
   input wire logic [NUM_SRC-1:0] maskFlag,
   input wire logic [NUM_SRC-1:0] urgencySelectFlag,
   input wire logic [15:0] cpuAddr,
   input wire logic cpuWrEn,
   input wire logic [7:0] cpuWrData,
   input wire logic cpuBitEn,
   input wire logic [2:0] cpuBitIdx,
   input wire logic cpuBitVal,
   input wire logic cpuRdEn,
   output logic [7:0] cpuRdData,
   input wire logic instrBoundary,
   input wire logic holdInstr,
   input wire logic unmaskAllOp,
   input wire logic maskAllOp,
   input wire logic softTrapOp,
   input wire logic irqReturnOp,
   input wire logic trapReturnOp,
   input wire logic pswPopOp,
   input wire logic pswPushOp,
   input wire logic [7:0] stackPopData,
   input wire logic [15:0] pcIn,
   output logic stackPush,
   output logic [15:0] stackData,
   output logic vecLoad,
   output logic [15:0] vecAddr,
   output logic [NUM_SRC-1:0] requestFlag,
   output logic [7:0] procStatusWord,
   output logic seqBusy
);
   logic [7:0] riseSel_q;
   logic [7:0] fallSel_q;
   logic [7:0] psw_q;
   logic [NUM_SRC-1:0] req_q;
   logic [NUM_SRC-1:0] req_d;
   logic [NUM_SRC-1:0] setVec;
   logic [NUM_SRC-1:0] clrVec;
   logic [NUM_PINS-1:0] edgeHit;
   logic blockNext_q;
   via_seq_type state_q;
   logic [CNT_W-1:0] waitCnt_q;
   logic isTrap_q;
   logic [SRC_W-1:0] srcIdx_q;
   logic srcUrg_q;
   logic stackPush_q;
   logic [15:0] stackData_q;
   logic vecLoad_q;
   logic [15:0] vecAddr_q;
   logic [7:0] rdData_q;
   logic wrRise;
   logic wrFall;
   logic wrPsw;
   logic bitRise;
   logic bitFall;
   logic bitPsw;
   logic trapStart;
   logic acceptOk;
   logic acceptSetSame;

   via_arb_if arbBus ();

   // Replace one bit of a byte
   function automatic logic [7:0] bitUpd(input logic [7:0] old,
      input logic [2:0] idx, input logic val);
      logic [7:0] res;
      res = old;
      res[idx] = val;
      return res;
   endfunction

   // Address decode
   assign wrRise = cpuWrEn && (cpuAddr == ADDR_RISE_SEL);
   assign wrFall = cpuWrEn && (cpuAddr == ADDR_FALL_SEL);
   assign wrPsw = cpuWrEn && (cpuAddr == ADDR_PSW);
   assign bitRise = cpuBitEn && (cpuAddr == ADDR_RISE_SEL);
   assign bitFall = cpuBitEn && (cpuAddr == ADDR_FALL_SEL);
   assign bitPsw = cpuBitEn && (cpuAddr == ADDR_PSW);

   // Edge select registers
   always_ff @(posedge mclk) begin
      if (rst) begin
         riseSel_q <= EDGE_SEL_RESET;
         fallSel_q <= EDGE_SEL_RESET;
      end else begin
         if (wrRise) begin
            riseSel_q <= cpuWrData;
         end else if (bitRise) begin
            riseSel_q <= bitUpd(riseSel_q, cpuBitIdx, cpuBitVal);
         end
         if (wrFall) begin
            fallSel_q <= cpuWrData;
         end else if (bitFall) begin
            fallSel_q <= bitUpd(fallSel_q, cpuBitIdx, cpuBitVal);
         end
      end
   end

   via_edge_detect uEdge (
      .mclk(mclk),
      .rst(rst),
      .pin(extIrqPin),
      .riseSel(riseSel_q),
      .fallSel(fallSel_q),
      .edgeHit(edgeHit)
   );

   // Request flags: a new event wins over the accept clear
   assign setVec = {periphReq, edgeHit};
   assign req_d = (req_q & ~clrVec) | setVec;

   always_ff @(posedge mclk) begin
      if (rst) begin
         req_q <= '0;
      end else begin
         req_q <= req_d;
      end
   end

   // Arbiter inputs
   assign arbBus.ready = req_q & ~maskFlag;
   assign arbBus.urgency = urgencySelectFlag;
   assign arbBus.accEn = psw_q[ACC_EN_BIT];
   assign arbBus.svcLvl = psw_q[SVC_LVL_BIT];

   via_arbiter uArb (
      .bus(arbBus)
   );

   // Acceptance at an instruction boundary
   assign trapStart = (state_q == VIA_IDLE) && softTrapOp;
   assign acceptOk = (state_q == VIA_IDLE) && instrBoundary &&
      !holdInstr && !blockNext_q && !softTrapOp &&
      !irqReturnOp && !trapReturnOp && arbBus.grant;
   assign acceptSetSame = setVec[arbBus.grantIdx];
   assign clrVec = acceptOk ?
      (NUM_SRC'(1) << arbBus.grantIdx) : '0;

   // Hold off one instruction after a return
   always_ff @(posedge mclk) begin
      if (rst) begin
         blockNext_q <= 1'b0;
      end else if (irqReturnOp || trapReturnOp) begin
         blockNext_q <= 1'b1;
      end else if (instrBoundary) begin
         blockNext_q <= 1'b0;
      end
   end

   // Stacking and vector sequencer
   always_ff @(posedge mclk) begin
      if (rst) begin
         state_q <= VIA_IDLE;
         waitCnt_q <= '0;
         isTrap_q <= 1'b0;
         srcIdx_q <= '0;
         srcUrg_q <= 1'b1;
      end else begin
         case (state_q)
            VIA_IDLE: begin
               if (trapStart) begin
                  isTrap_q <= 1'b1;
                  state_q <= VIA_PUSH_PSW;
               end else if (acceptOk) begin
                  isTrap_q <= 1'b0;
                  srcIdx_q <= arbBus.grantIdx;
                  srcUrg_q <= arbBus.grantUrg;
                  waitCnt_q <= arbBus.grantUrg ?
                     WAIT_LO_CNT : WAIT_HI_CNT;
                  state_q <= VIA_WAIT;
               end
            end
            VIA_WAIT: begin
               if (waitCnt_q == '0) begin
                  state_q <= VIA_PUSH_PSW;
               end else begin
                  waitCnt_q <= waitCnt_q - CNT_W'(1);
               end
            end
            VIA_PUSH_PSW: begin
               state_q <= VIA_PUSH_PC;
            end
            VIA_PUSH_PC: begin
               state_q <= VIA_LOAD_VEC;
            end
            VIA_LOAD_VEC: begin
               state_q <= VIA_IDLE;
            end
            default: begin
               state_q <= VIA_IDLE;
            end
         endcase
      end
   end

   // Status word updates
   always_ff @(posedge mclk) begin
      if (rst) begin
         psw_q <= PSW_RESET;
      end else if (state_q == VIA_PUSH_PSW) begin
         psw_q[ACC_EN_BIT] <= 1'b0;
         if (!isTrap_q) begin
            psw_q[SVC_LVL_BIT] <= srcUrg_q;
         end
      end else if (irqReturnOp || trapReturnOp || pswPopOp) begin
         psw_q <= stackPopData;
      end else if (unmaskAllOp) begin
         psw_q[ACC_EN_BIT] <= 1'b1;
      end else if (maskAllOp) begin
         psw_q[ACC_EN_BIT] <= 1'b0;
      end else if (wrPsw) begin
         psw_q <= cpuWrData;
      end else if (bitPsw) begin
         psw_q <= bitUpd(psw_q, cpuBitIdx, cpuBitVal);
      end
   end

   // Stack and vector strobes, one cycle after each state
   always_ff @(posedge mclk) begin
      if (rst) begin
         stackPush_q <= 1'b0;
         stackData_q <= '0;
         vecLoad_q <= 1'b0;
         vecAddr_q <= '0;
      end else begin
         stackPush_q <= 1'b0;
         vecLoad_q <= 1'b0;
         if (state_q == VIA_PUSH_PSW) begin
            stackPush_q <= 1'b1;
            stackData_q <= {8'h00, psw_q};
         end else if (state_q == VIA_PUSH_PC) begin
            stackPush_q <= 1'b1;
            stackData_q <= pcIn;
         end else if (state_q == VIA_LOAD_VEC) begin
            vecLoad_q <= 1'b1;
            vecAddr_q <= isTrap_q ? VEC_TRAP :
               16'(VEC_BASE + {srcIdx_q, 1'b0});
         end else if (pswPushOp) begin
            stackPush_q <= 1'b1;
            stackData_q <= {8'h00, psw_q};
         end
      end
   end

   // Register read port
   always_ff @(posedge mclk) begin
      if (rst) begin
         rdData_q <= RD_UNMAPPED;
      end else if (cpuRdEn) begin
         case (cpuAddr)
            ADDR_RISE_SEL: rdData_q <= riseSel_q;
            ADDR_FALL_SEL: rdData_q <= fallSel_q;
            ADDR_PSW: rdData_q <= psw_q;
            default: rdData_q <= RD_UNMAPPED;
         endcase
      end
   end

   // Outputs
   assign cpuRdData = rdData_q;
   assign stackPush = stackPush_q;
   assign stackData = stackData_q;
   assign vecLoad = vecLoad_q;
   assign vecAddr = vecAddr_q;
   assign requestFlag = req_q;
   assign procStatusWord = psw_q;
   assign seqBusy = (state_q != VIA_IDLE);

   // Checks
   resetPsw_a: assert property (@(posedge mclk)
      $fell(rst) |-> psw_q == PSW_RESET)
      else $error("status word not 02H after reset");
   resetEdge_a: assert property (@(posedge mclk)
      $fell(rst) |-> (riseSel_q == 8'h00) && (fallSel_q == 8'h00))
      else $error("edge selects not cleared by reset");
   unmaskSet_a: assert property (@(posedge mclk) disable iff (rst)
      unmaskAllOp && !maskAllOp && (state_q != VIA_PUSH_PSW) &&
      !irqReturnOp && !trapReturnOp && !pswPopOp |=> psw_q[ACC_EN_BIT])
      else $error("enable flag not set by unmask op");
   acceptIe_a: assert property (@(posedge mclk) disable iff (rst)
      (state_q == VIA_IDLE) ##1 (state_q == VIA_WAIT) |->
      $past(psw_q[ACC_EN_BIT]))
      else $error("request accepted with enable clear");
   lvlBlock_a: assert property (@(posedge mclk) disable iff (rst)
      (state_q == VIA_IDLE) ##1 (state_q == VIA_WAIT) |->
      $past(psw_q[SVC_LVL_BIT]) || !srcUrg_q)
      else $error("low request accepted during high handler");
   latHi_a: assert property (@(posedge mclk) disable iff (rst)
      acceptOk && !arbBus.grantUrg |-> !vecLoad [*6] ##1 vecLoad)
      else $error("high request latency not 6 after accept");
   latLo_a: assert property (@(posedge mclk) disable iff (rst)
      acceptOk && arbBus.grantUrg |-> !vecLoad [*7] ##1 vecLoad)
      else $error("low request latency not 7 after accept");
   levelFirst_a: assert property (@(posedge mclk) disable iff (rst)
      acceptOk && |(arbBus.ready & ~urgencySelectFlag) &&
      psw_q[SVC_LVL_BIT] |-> !arbBus.grantUrg)
      else $error("low level won over high level");
   stackOrder_a: assert property (@(posedge mclk) disable iff (rst)
      (state_q == VIA_PUSH_PSW) |=> stackPush &&
      (stackData[7:0] == $past(psw_q)) && !psw_q[ACC_EN_BIT]
      ##1 stackPush ##1 vecLoad)
      else $error("stacking order or enable clear wrong");
   lvlCopy_a: assert property (@(posedge mclk) disable iff (rst)
      (state_q == VIA_PUSH_PSW) && !isTrap_q |=>
      psw_q[SVC_LVL_BIT] == $past(srcUrg_q))
      else $error("service level not copied from urgency");
   trapVec_a: assert property (@(posedge mclk) disable iff (rst)
      trapStart |-> ##4 vecLoad && (vecAddr == VEC_TRAP))
      else $error("trap vector not loaded");
   returnHold_a: assert property (@(posedge mclk) disable iff (rst)
      irqReturnOp || trapReturnOp |-> !acceptOk ##1 !acceptOk)
      else $error("accept right after return");
   flagClear_a: assert property (@(posedge mclk) disable iff (rst)
      acceptOk && !acceptSetSame |=> !requestFlag[srcIdx_q])
      else $error("request flag not cleared on accept");
endmodule // via_irq_ctrl

// ---- bench/via_core_model.sv ----
`timescale 1ns/1ps
// Core stand-in: ends instructions and follows vector jumps
module via_core_model #(
   parameter int GAP = 3
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic seqBusy,
   input wire logic vecLoad,
   input wire logic [15:0] vecAddr,
   output logic instrBoundary,
   output logic [15:0] pcIn
);
   logic [3:0] cnt_q;

   // Boundary pulse every GAP cycles, none while the sequencer runs
   always_ff @(posedge mclk) begin
      if (rst) begin
         cnt_q <= 4'h0;
         instrBoundary <= 1'b0;
      end else begin
         instrBoundary <= !seqBusy && cnt_q == 4'(GAP - 1);
         cnt_q <= (cnt_q == 4'(GAP - 1)) ? 4'h0 : cnt_q + 4'h1;
      end
   end

   // Program counter only moves on a vector jump, so pushes are known
   always_ff @(posedge mclk) begin
      if (rst) begin
         pcIn <= 16'h1234;
      end else if (vecLoad) begin
         pcIn <= vecAddr;
      end
   end
endmodule // via_core_model

// ---- bench/vectored_interrupt_acceptance_bench.sv ----
`timescale 1ns/1ps
module vectored_interrupt_acceptance_bench import via_pkg::*;;
   typedef struct {
      logic [7:0] req;
      logic [7:0] urg;
      int s1;
      int s2;
   } via_row_type;
   logic mclk, rst, u;
   logic [7:0] extIrqPin, periphReq, cpuWrData, cpuRdData;
   logic [7:0] procStatusWord, stackPopData, psw0;
   logic [15:0] maskFlag, urgencySelectFlag, cpuAddr, stackData, vecAddr;
   logic [15:0] requestFlag, pcIn, pc0;
   logic cpuWrEn, cpuBitEn, cpuBitVal, cpuRdEn, stackPush, vecLoad;
   logic seqBusy, instrBoundary;
   logic [2:0] cpuBitIdx;
   logic [6:0] opsV;
   logic [15:0] pushLog[$];
   int nMismatch = 0, comparisons = 0, n, lo, hi;
   // Periph pulses, their levels, first and held source
   via_row_type rows[5] = '{'{8'h01, 8'h00, 8, -1},
      '{8'h01, 8'h01, 8, -1}, '{8'h06, 8'h02, 10, 9},
      '{8'h0C, 8'h00, 10, 11}, '{8'h90, 8'hFF, 12, 15}};

   via_irq_ctrl u_dut (.mclk(mclk), .rst(rst), .extIrqPin(extIrqPin),
      .periphReq(periphReq), .maskFlag(maskFlag),
      .urgencySelectFlag(urgencySelectFlag), .cpuAddr(cpuAddr),
      .cpuWrEn(cpuWrEn), .cpuWrData(cpuWrData), .cpuBitEn(cpuBitEn),
      .cpuBitIdx(cpuBitIdx), .cpuBitVal(cpuBitVal), .cpuRdEn(cpuRdEn),
      .cpuRdData(cpuRdData), .instrBoundary(instrBoundary),
      .holdInstr(1'b0), .unmaskAllOp(opsV[0]), .maskAllOp(opsV[1]),
      .softTrapOp(opsV[2]), .irqReturnOp(opsV[3]),
      .trapReturnOp(opsV[4]), .pswPopOp(opsV[5]), .pswPushOp(opsV[6]),
      .stackPopData(stackPopData), .pcIn(pcIn), .stackPush(stackPush),
      .stackData(stackData), .vecLoad(vecLoad), .vecAddr(vecAddr),
      .requestFlag(requestFlag), .procStatusWord(procStatusWord),
      .seqBusy(seqBusy));

   via_core_model u_core (.mclk(mclk), .rst(rst), .seqBusy(seqBusy),
      .vecLoad(vecLoad), .vecAddr(vecAddr),
      .instrBoundary(instrBoundary), .pcIn(pcIn));

   // Clock
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   // Log of stacked words
   always @(posedge mclk) begin
      if (stackPush === 1'b1) begin
         pushLog.push_back(stackData);
      end
   end

   task automatic finish_test;
      if (nMismatch == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         nMismatch++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // One core event pulse; d rides along as the popped byte
   task automatic pulse(input int b, input logic [7:0] d);
      @(posedge mclk);
      opsV[b] <= 1'b1;
      stackPopData <= d;
      @(posedge mclk);
      opsV[b] <= 1'b0;
      stackPopData <= ~d;
   endtask

   // Register access: k 0 byte write, 1 bit op, 2 read
   task automatic acc(input logic [15:0] a, input logic [7:0] d,
      input int k);
      @(posedge mclk);
      cpuAddr <= a;
      cpuWrData <= d;
      cpuBitIdx <= d[2:0];
      cpuBitVal <= d[3];
      cpuWrEn <= k == 0;
      cpuBitEn <= k == 1;
      cpuRdEn <= k == 2;
      @(posedge mclk);
      {cpuWrEn, cpuBitEn, cpuRdEn} <= 3'h0;
      #1;
   endtask

   task automatic snap;
      #1;
      psw0 = procStatusWord;
      pc0 = pcIn;
   endtask

   // Bounded wait for a vector load; n reaches 60 if none comes
   task automatic wv;
      n = 0;
      pushLog.delete();
      do begin
         @(posedge mclk);
         n++;
      end while (vecLoad !== 1'b1 && n < 60);
   endtask

   task automatic fire(input logic [7:0] r);
      @(posedge mclk);
      periphReq <= r;
      @(posedge mclk);
      periphReq <= 8'h00;
      wv();
   endtask

   task automatic expv(input logic [15:0] va);
      chk(vecAddr, va);
      chk(16'(pushLog.size()), 16'h0002);
      chk(pushLog[0], {8'h00, psw0});
      chk(pushLog[1], pc0);
   endtask

   // Watchdog
   initial begin
      repeat (20000) @(posedge mclk);
      nMismatch++;
      finish_test();
   end

   initial begin
      rst = 1'b1;
      {extIrqPin, periphReq, cpuWrData, stackPopData} = 32'h0;
      {opsV, cpuBitIdx, cpuWrEn, cpuBitEn, cpuBitVal, cpuRdEn} = 14'h0;
      maskFlag = 16'h00FF;
      urgencySelectFlag = 16'hE000;
      cpuAddr = 16'h0000;
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      acc(ADDR_RISE_SEL, 8'h00, 2);
      chk(cpuRdData, EDGE_SEL_RESET);
      chk(procStatusWord, PSW_RESET);
      acc(16'hFF50, 8'h00, 2);
      chk(cpuRdData, RD_UNMAPPED);
      // Ordinary acceptances, then the held one after return
      foreach (rows[i]) begin
         urgencySelectFlag[15:8] <= rows[i].urg | 8'hE0;
         pulse(0, 8'h00);
         snap();
         fire(rows[i].req);
         u = rows[i].urg[rows[i].s1 - 8];
         lo = u ? LAT_MIN_LO_CLK : LAT_MIN_HI_CLK;
         hi = u ? LAT_MAX_LO_CLK : LAT_MAX_HI_CLK;
         chk(16'(n >= lo && n <= hi), 16'h0001);
         expv(VEC_BASE + 16'(2 * rows[i].s1));
         #1;
         chk({procStatusWord[7], procStatusWord[1]}, {1'b0, u});
         chk(requestFlag[rows[i].s1], 1'b0);
         pulse(3, psw0);
         #1;
         chk(procStatusWord, psw0);
         if (rows[i].s2 >= 0) begin
            snap();
            wv();
            expv(VEC_BASE + 16'(2 * rows[i].s2));
            pulse(3, psw0);
         end
      end
      // Edge selection on masked pins: flags stay pending
      acc(ADDR_RISE_SEL, 8'h0C, 0);
      acc(ADDR_FALL_SEL, 8'h0A, 0);
      acc(ADDR_RISE_SEL, 8'h00, 2);
      chk(cpuRdData, 8'h0C);
      extIrqPin <= 8'h0F;
      repeat (3) @(posedge mclk);
      #1;
      chk(requestFlag[3:0], 4'hC);
      extIrqPin <= 8'h00;
      repeat (3) @(posedge mclk);
      #1;
      chk(requestFlag[3:0], 4'hE);
      acc(ADDR_RISE_SEL, 8'h00, 0);
      acc(ADDR_FALL_SEL, 8'h00, 0);
      // Reset in mid-run
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      acc(ADDR_FALL_SEL, 8'h00, 2);
      chk(cpuRdData, EDGE_SEL_RESET);
      chk(procStatusWord, PSW_RESET);
      chk(requestFlag, 16'h0000);
      // Held while disabled, trap taken anyway, then nesting
      urgencySelectFlag <= 16'hE200;
      fire(8'h02);
      chk(16'(n), 16'h003C);
      chk(requestFlag[9], 1'b1);
      snap();
      pulse(2, 8'h00);
      wv();
      expv(VEC_TRAP);
      #1;
      chk(procStatusWord, PSW_RESET);
      snap();
      pulse(0, 8'h00);
      psw0 = 8'h82;
      wv();
      expv(VEC_BASE + 16'h0012);
      pulse(0, 8'h00);
      snap();
      fire(8'h01);
      expv(VEC_BASE + 16'h0010);
      pulse(0, 8'h00);
      fire(8'h02);
      chk(16'(n), 16'h003C);
      snap();
      fire(8'h04);
      expv(VEC_BASE + 16'h0014);
      // Status word access paths
      pulse(0, 8'h00);
      #1;
      chk(procStatusWord[7], 1'b1);
      pulse(1, 8'h00);
      #1;
      chk(procStatusWord[7], 1'b0);
      acc(ADDR_PSW, 8'h0F, 1);
      chk(procStatusWord[7], 1'b1);
      acc(ADDR_PSW, 8'h02, 0);
      acc(ADDR_PSW, 8'h00, 2);
      chk(cpuRdData, 8'h02);
      pushLog.delete();
      pulse(6, 8'h00);
      repeat (2) @(posedge mclk);
      chk(pushLog[0], 16'h0002);
      pulse(5, 8'h43);
      #1;
      chk(procStatusWord, 8'h43);
      pulse(4, 8'h02);
      #1;
      chk(procStatusWord, 8'h02);
      finish_test();
   end
endmodule // vectored_interrupt_acceptance_bench
